// ### pkg/i2m_pkg.sv
// Constants and types for the multi-address 10-bit I2C target matcher.
// How it works
// (RULE1) Up to four enabled 10-bit own addresses are held and matched.
// (RULE2) A 10-bit address arrives as two bytes after a start condition.
// (RULE3) First byte is 11110, two upper address bits, then read/write bit.
// (RULE4) Second byte holds the low eight bits, compared against own addresses.
// (RULE5) First byte is acknowledged when it is a write header whose upper bits match any own address.
// (RULE6) Second byte is acknowledged only when all ten bits match one address.
// (RULE7) Upper bits of one address with low bits of another are refused.
// (RULE8) The addressed state and data reception follow only a full match.
// (RULE9) Software should give all own addresses identical upper two bits.
// (RULE10) First-byte candidates are kept; second byte compares only against them.
package i2m_pkg;

  localparam int unsigned NUM_ADDR = 4;
  localparam int unsigned ADDR_W   = 10;
  localparam int unsigned BYTE_W   = 8;
  localparam int unsigned IDX_W    = 2;

  // Header byte layout.
  localparam logic [4:0] HDR_PREFIX = 5'h1e;
  localparam int unsigned HDR_PFX_HI = 7;
  localparam int unsigned HDR_PFX_LO = 3;
  localparam int unsigned HDR_UP_HI  = 2;
  localparam int unsigned HDR_UP_LO  = 1;
  localparam int unsigned HDR_RW     = 0;
  localparam int unsigned ADDR_UP_HI = 9;
  localparam int unsigned ADDR_UP_LO = 8;
  localparam int unsigned ADDR_LO_HI = 7;

  // Bit counter value of the eighth bit of a byte.
  localparam logic [2:0] BIT_LAST = 3'h7;

  // Acknowledge slot phases.
  localparam logic [1:0] PH_FALL1 = 2'h0;
  localparam logic [1:0] PH_RISE  = 2'h1;
  localparam logic [1:0] PH_FALL2 = 2'h2;

  // Idle level of the synchronised bus lines.
  localparam logic BUS_IDLE = 1'h1;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_HDR      = 3'b001,
    ST_HDR_ACK  = 3'b010,
    ST_LOW      = 3'b011,
    ST_LOW_ACK  = 3'b100,
    ST_DATA     = 3'b101,
    ST_DATA_ACK = 3'b110
  } i2m_state_t;

  // Lowest set bit of a match vector as an index.
  function automatic logic [IDX_W-1:0] i2m_first(input logic [NUM_ADDR-1:0] v);
    logic [IDX_W-1:0] r;
    r = '0;
    for (int i = NUM_ADDR - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = IDX_W'(i);
      end
    end
    return r;
  endfunction : i2m_first

endpackage : i2m_pkg

// ### rtl/i2m_buf2.sv
// Two-entry buffer between the byte receiver and the user side.
`timescale 1ns/10ps
`default_nettype none
module i2m_buf2
  import i2m_pkg::*;
(
  input  wire logic              i_mclk,    // System clock.
  input  wire logic              i_arst_n,  // Asynchronous reset, active low.
  input  wire logic              i_ce,      // Clock enable.
  input  wire logic              i_valid,   // Fill side word valid.
  input  wire logic [BYTE_W-1:0] i_data,    // Fill side word.
  output logic                   o_ready,   // Room for a word.
  output logic                   o_valid,   // Drain side word valid.
  output logic      [BYTE_W-1:0] o_data,    // Drain side word, registered.
  input  wire logic              i_ready    // Drain side accepts.
);

  typedef struct packed {
    logic              hv;
    logic [BYTE_W-1:0] hd;
    logic              tv;
    logic [BYTE_W-1:0] td;
  } i2m_buf_t;

  i2m_buf_t q;
  i2m_buf_t d;
  logic     pop;
  logic     push;

  assign pop     = q.hv & i_ready;
  assign push    = i_valid & ~q.tv;
  assign o_ready = ~q.tv;

  // The head slot is the output register; the tail slot moves up on a pop.
  always_comb begin
    d = q;
    if (pop) begin
      d.hv = q.tv;
      d.hd = q.td;
      d.tv = 1'b0;
    end
    if (push) begin
      if (!d.hv) begin
        d.hv = 1'b1;
        d.hd = i_data;
      end else begin
        d.tv = 1'b1;
        d.td = i_data;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= '0;
    end else if (i_ce) begin
      q <= d;
    end
  end

  assign o_valid = q.hv;
  assign o_data  = q.hd;

endmodule : i2m_buf2
`default_nettype wire

// ### rtl/i2m_sync.sv
// Three-stage input synchroniser with agreement filter for the bus lines.
`timescale 1ns/10ps
`default_nettype none
module i2m_sync
  import i2m_pkg::*;
#(
  parameter int unsigned W = 2
) (
  input  wire logic         i_mclk,   // System clock.
  input  wire logic         i_arst_n, // Asynchronous reset, active low.
  input  wire logic         i_ce,     // Clock enable.
  input  wire logic [W-1:0] i_async,  // Lines from the pins.
  output logic      [W-1:0] o_sync    // Filtered lines, combined from the stages without a register.
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] val;
  } i2m_sync_t;

  i2m_sync_t q;
  i2m_sync_t d;

  // The first stage feeds only the second; the value moves once stages two
  // and three agree, which rejects single-sample glitches.
  always_comb begin
    d    = q;
    d.s1 = i_async;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.val[i] = q.s3[i];
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= {4{{W{BUS_IDLE}}}};
    end else if (i_ce) begin
      q <= d;
    end
  end

  // The agreed value is used without a further register. One more cycle
  // would push the acknowledge past the low half of the bus clock.
  assign o_sync = (q.s3 & ~(q.s2 ^ q.s3)) | (q.val & (q.s2 ^ q.s3));

endmodule : i2m_sync
`default_nettype wire

// ### rtl/i2m_target.sv
// I2C target with four 10-bit own addresses and strict full-address match.
`timescale 1ns/10ps
`default_nettype none
module i2m_target
  import i2m_pkg::*;
(
  input  wire logic                             i_mclk,      // 50 MHz clock.
  input  wire logic                             i_arst_n,    // Reset, low.
  input  wire logic                             i_ce,        // Clock enable.
  input  wire logic                             i_scl,       // Bus clock pin.
  input  wire logic                             i_sda,       // Bus data pin.
  output logic                                  o_sda_o,     // Data out, 0.
  output logic                                  o_sda_oe,    // Pull data low.
  input  wire logic [NUM_ADDR-1:0][ADDR_W-1:0]  i_own_addr,  // Own addresses.
  input  wire logic [NUM_ADDR-1:0]              i_own_en,    // Address enables.
  output logic                                  o_addressed, // Full match held.
  output logic      [IDX_W-1:0]                 o_hit_idx,   // Matched address.
  output logic                                  o_rx_valid,  // Byte valid.
  output logic      [BYTE_W-1:0]                o_rx_data,   // Received byte.
  input  wire logic                             i_rx_ready   // Byte taken.
);

  typedef struct packed {
    i2m_state_t        st;
    logic [BYTE_W-1:0] sh;
    logic [2:0]        cnt;
    logic [1:0]        ph;
    logic              ack;
    logic [NUM_ADDR-1:0] cand;
    logic [IDX_W-1:0]  hit;
    logic              addressed;
    logic              oe;
    logic              scl;
    logic              sda;
    logic              push;
    logic [BYTE_W-1:0] pdat;
  } i2m_tgt_t;

  i2m_tgt_t            q;
  i2m_tgt_t            d;
  logic [1:0]          bus;
  logic                s_scl;
  logic                s_sda;
  logic                buf_ready;
  logic [BYTE_W-1:0]   sh_n;
  logic [NUM_ADDR-1:0] up_w;
  logic [NUM_ADDR-1:0] full_w;
  logic                hdr_ok;

  i2m_sync #(
    .W (2)
  ) u_sync (
    .i_mclk   (i_mclk),
    .i_arst_n (i_arst_n),
    .i_ce     (i_ce),
    .i_async  ({i_scl, i_sda}),
    .o_sync   (bus)
  );

  assign s_scl = bus[1];
  assign s_sda = bus[0];

  // Byte as it stands once the current bit is shifted in.
  assign sh_n = {q.sh[BYTE_W-2:0], s_sda};

  // Per-address comparison of upper bits and of the low byte.
  for (genvar g = 0; g < NUM_ADDR; g++) begin : g_cmp
    assign up_w[g] = i_own_en[g] &&
      (i_own_addr[g][ADDR_UP_HI:ADDR_UP_LO] == sh_n[HDR_UP_HI:HDR_UP_LO]); // [RULE1] [RULE5]
    assign full_w[g] = q.cand[g] &&
      (i_own_addr[g][ADDR_LO_HI:0] == sh_n); // [RULE4] [RULE6] [RULE7] [RULE10]
  end

  assign hdr_ok = (sh_n[HDR_PFX_HI:HDR_PFX_LO] == HDR_PREFIX) &&
                  !sh_n[HDR_RW]; // [RULE3]

  always_comb begin
    logic rise;
    logic fall;
    logic start;
    logic stop;
    rise   = s_scl & ~q.scl;
    fall   = ~s_scl & q.scl;
    start  = s_scl & q.scl & q.sda & ~s_sda;
    stop   = s_scl & q.scl & ~q.sda & s_sda;
    d      = q;
    d.scl  = s_scl;
    d.sda  = s_sda;
    d.push = 1'b0;
    if (start) begin
      d.st        = ST_HDR; // [RULE2]
      d.cnt       = '0;
      d.oe        = 1'b0;
      d.addressed = 1'b0;
    end else if (stop) begin
      d.st        = ST_IDLE;
      d.oe        = 1'b0;
      d.addressed = 1'b0;
    end else begin
      case (q.st)
        ST_HDR, ST_LOW, ST_DATA: begin
          if (rise) begin
            d.sh  = sh_n;
            d.cnt = q.cnt + 3'h1;
            if (q.cnt == BIT_LAST) begin
              d.ph = PH_FALL1;
              if (q.st == ST_HDR) begin
                d.cand = up_w; // [RULE10]
                d.ack  = hdr_ok && (|up_w); // [RULE5]
                d.st   = ST_HDR_ACK;
              end else if (q.st == ST_LOW) begin
                d.ack = |full_w; // [RULE6] [RULE7]
                d.hit = i2m_first(full_w);
                d.st  = ST_LOW_ACK;
              end else begin
                d.ack  = buf_ready;
                d.push = buf_ready;
                d.pdat = sh_n;
                d.st   = ST_DATA_ACK;
              end
            end
          end
        end
        ST_HDR_ACK, ST_LOW_ACK, ST_DATA_ACK: begin
          if (fall && q.ph == PH_FALL1) begin
            d.oe = q.ack;
            d.ph = PH_RISE;
          end else if (rise && q.ph == PH_RISE) begin
            d.ph = PH_FALL2;
          end else if (fall && q.ph == PH_FALL2) begin
            d.oe  = 1'b0;
            d.cnt = '0;
            if (!q.ack) begin
              d.st        = ST_IDLE; // [RULE10]
              d.addressed = 1'b0;
            end else if (q.st == ST_HDR_ACK) begin
              d.st = ST_LOW; // [RULE2]
            end else begin
              d.st        = ST_DATA; // [RULE8]
              d.addressed = 1'b1;
            end
          end
        end
        default: begin
          d.oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q     <= '0;
      q.scl <= BUS_IDLE;
      q.sda <= BUS_IDLE;
    end else if (i_ce) begin
      q <= d;
    end
  end

  // Only bytes of a fully matched transfer enter the buffer.
  i2m_buf2 u_buf (
    .i_mclk   (i_mclk),
    .i_arst_n (i_arst_n),
    .i_ce     (i_ce),
    .i_valid  (q.push), // [RULE8]
    .i_data   (q.pdat),
    .o_ready  (buf_ready),
    .o_valid  (o_rx_valid),
    .o_data   (o_rx_data),
    .i_ready  (i_rx_ready)
  );

  assign o_sda_o     = 1'b0;
  assign o_sda_oe    = q.oe;
  assign o_addressed = q.addressed;
  assign o_hit_idx   = q.hit;

endmodule : i2m_target
`default_nettype wire

// ### sim/i2m_master.sv
// Behavioural bus master that writes frames to the target.
`timescale 1ns/10ps
`default_nettype none
module i2m_master (
  output logic      o_scl, // Bus clock, idle high.
  output logic      o_sda, // Data drive, 1 means released.
  input  wire logic i_sda  // Resolved data line.
);
  logic ack;
  event ack_done;
  initial begin
    o_scl = 1'h1;
    o_sda = 1'h1;
  end
  task automatic start();
    #80 o_sda = 1'h0;
    #80 o_scl = 1'h0;
  endtask : start
  task automatic stop();
    #20 o_sda = 1'h0;
    #60 o_scl = 1'h1;
    #80 o_sda = 1'h1;
    #80;
  endtask : stop
  task automatic send(input logic [7:0] b);
    for (int i = 8; i >= 0; i--) begin
      #20 o_sda = (i > 0) ? b[i-1] : 1'h1;
      #60 o_scl = 1'h1;
      #40 ack = ~i_sda;
      #40 o_scl = 1'h0;
    end
    -> ack_done;
  endtask : send
endmodule : i2m_master
`default_nettype wire

// ### sim/i2m_target_checker.sv
// Concurrent checks on the ports of the 10-bit multi-address target.
`timescale 1ns/10ps
`default_nettype none
module i2m_target_checker
  import i2m_pkg::*;
(
  input wire logic                            i_mclk,      // Clock.
  input wire logic                            i_arst_n,    // Reset.
  input wire logic                            i_ce,        // Enable.
  input wire logic                            i_scl,       // Bus clock.
  input wire logic                            i_sda,       // Bus data.
  input wire logic                            o_sda_o,     // Data value.
  input wire logic                            o_sda_oe,    // Data pull.
  input wire logic [NUM_ADDR-1:0][ADDR_W-1:0] i_own_addr,  // Addresses.
  input wire logic [NUM_ADDR-1:0]             i_own_en,    // Enables.
  input wire logic                            o_addressed, // Matched.
  input wire logic [IDX_W-1:0]                o_hit_idx,   // Match index.
  input wire logic                            o_rx_valid,  // Byte valid.
  input wire logic [BYTE_W-1:0]               o_rx_data,   // Byte.
  input wire logic                            i_rx_ready   // Byte taken.
);
  logic [5:0] ack_len_q;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  always_ff @(posedge i_mclk or negedge i_arst_n)
    if (!i_arst_n) ack_len_q <= 6'h0;
    else ack_len_q <= o_sda_oe ? ack_len_q + 6'h1 : 6'h0;
  AST_SDA_ZERO: assert property (o_sda_o == 1'h0)
    else $error("data output value not zero");
  AST_ACK_START: assert property ($rose(o_sda_oe) |-> $past(!i_scl, 2))
    else $error("acknowledge began outside a low bus clock");
  AST_ACK_STANDS: assert property ($rose(i_scl) && o_sda_oe |-> o_sda_oe [*4])
    else $error("acknowledge dropped during high bus clock");
  AST_ACK_END: assert property ($fell(o_sda_oe) |-> $past(!i_scl, 2))
    else $error("acknowledge ended outside a low bus clock");
  AST_ACK_LEN: assert property (ack_len_q < 6'h0c)
    else $error("acknowledge held too long");
  AST_ADDR_EN: assert property ($rose(o_addressed) |-> i_own_en[o_hit_idx])
    else $error("match on a disabled address");
  AST_HIT_STABLE: assert property (o_addressed && $past(o_addressed) |->
    $stable(o_hit_idx)) else $error("match index moved while addressed");
  AST_RXV_ADDR: assert property ($rose(o_rx_valid) |->
    $past(o_addressed, 2) || $past(o_rx_valid, 2))
    else $error("byte delivered without an addressed state");
  AST_RX_HOLD: assert property (o_rx_valid && !i_rx_ready |=>
    o_rx_valid && $stable(o_rx_data)) else $error("stalled byte lost");
endmodule : i2m_target_checker
`default_nettype wire

// ### sim/i2m_target_tb.sv
// Self-checking bench for the multi-address 10-bit target.
`timescale 1ns/10ps
`default_nettype none
module i2m_target_tb;
  import i2m_pkg::*;
  logic                            i_mclk, i_arst_n, i_rx_ready, rdy_en, ce;
  logic                            scl, sda_m, sda_o, sda_oe, addressed;
  logic                            rx_valid;
  logic [NUM_ADDR-1:0][ADDR_W-1:0] own;
  logic [NUM_ADDR-1:0]             en;
  logic [IDX_W-1:0]                hit;
  logic [BYTE_W-1:0]               rx_data, r;
  logic                            q_ack[$];
  logic [BYTE_W-1:0]               q_byte[$];
  int                              fails, samples_checked;
  wire logic sda = sda_m & (~sda_oe | sda_o);
  i2m_target u_dut (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_ce(ce),
    .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
    .i_own_addr(own), .i_own_en(en), .o_addressed(addressed),
    .o_hit_idx(hit), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
    .i_rx_ready(i_rx_ready));
  i2m_master u_mst (.o_scl(scl), .o_sda(sda_m), .i_sda(sda));
  initial begin
    i_mclk = 1'h0;
    forever #10 i_mclk = ~i_mclk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic put(input logic [7:0] b, input logic e);
    q_ack.push_back(e);
    u_mst.send(b);
  endtask : put
  task automatic frame(input logic [9:0] a, input logic [7:0] hx,
    input logic e1, input logic e2, input logic [1:0] k, input int nd,
    input int na);
    logic [7:0] d;
    u_mst.start();
    put({HDR_PREFIX, a[9:8], 1'h0} ^ hx, e1);
    if (e1) put(a[7:0], e2);
    #120 chk(16'({addressed, hit & {2{addressed}}}),
             16'({e2, k & {2{e2}}}));
    for (int i = 0; i < nd; i++) begin
      d = 8'($urandom);
      if (i < na) q_byte.push_back(d);
      put(d, i < na);
    end
    u_mst.stop();
    #120 chk(16'(addressed), 16'h0);
  endtask : frame
  task automatic end_sim();
    $display("samples_checked=%0d fails=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  always @(u_mst.ack_done)
    chk(16'(u_mst.ack), 16'(q_ack.pop_front()));
  always @(posedge i_mclk)
    if (rx_valid && i_rx_ready)
      chk(16'(rx_data), 16'(q_byte.pop_front()));
  always @(negedge i_mclk) i_rx_ready <= rdy_en & 1'($urandom);
  initial begin
    #500000;
    fails++;
    end_sim();
  end
  initial begin
    void'($urandom(32'hf62dec4e));
    fails = 0;
    samples_checked = 0;
    i_arst_n = 1'h0;
    ce = 1'h1;
    rdy_en = 1'h1;
    i_rx_ready = 1'h0;
    en = '1;
    r = 8'($urandom);
    // Upper bits differ per address, so cross matches are possible.
    for (int k = 0; k < NUM_ADDR; k++) own[k] = {2'(k), r + 8'(k)};
    repeat (12) @(negedge i_mclk);
    i_arst_n = 1'h1;
    repeat (8) @(negedge i_mclk);
    for (int k = 0; k < NUM_ADDR; k++)
      frame(own[k], 8'h00, 1'h1, 1'h1, 2'(k), 2, 2);
    $display("full match test done");
    frame({own[0][9:8], own[1][7:0]}, 8'h00, 1'h1, 1'h0, 2'h0, 0, 0);
    $display("cross match test done");
    @(negedge i_mclk) en[3] = 1'h0;
    frame(own[3], 8'h00, 1'h0, 1'h0, 2'h0, 0, 0);
    @(negedge i_mclk) en[3] = 1'h1;
    frame(own[0], 8'h01, 1'h0, 1'h0, 2'h0, 0, 0);
    frame(own[0], 8'h80, 1'h0, 1'h0, 2'h0, 0, 0);
    $display("refused header test done");
    rdy_en = 1'h0;
    frame(own[2], 8'h00, 1'h1, 1'h1, 2'h2, 3, 2);
    rdy_en = 1'h1;
    repeat (40) @(negedge i_mclk);
    chk(16'(q_byte.size()), 16'h0);
    $display("full buffer test done");
    // A frozen idle spell must leave the target ready for the next frame.
    @(negedge i_mclk) ce = 1'h0;
    repeat (20) @(negedge i_mclk);
    ce = 1'h1;
    // Shared upper bits make all four addresses candidates of the header.
    for (int k = 0; k < NUM_ADDR; k++) own[k] = {2'h1, r + 8'(k)};
    frame(own[2], 8'h00, 1'h1, 1'h1, 2'h2, 1, 1);
    $display("shared upper bits test done");
    end_sim();
  end
endmodule : i2m_target_tb
bind i2m_target i2m_target_checker u_chk (.i_mclk(i_mclk),
  .i_arst_n(i_arst_n), .i_ce(i_ce), .i_scl(i_scl), .i_sda(i_sda),
  .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .i_own_addr(i_own_addr),
  .i_own_en(i_own_en), .o_addressed(o_addressed), .o_hit_idx(o_hit_idx),
  .o_rx_valid(o_rx_valid), .o_rx_data(o_rx_data), .i_rx_ready(i_rx_ready));
`default_nettype wire
